// ===== hdl/i2c_status_flags.v
// Purpose: status flags and masked slave address match of an I2C port
// Assumes: SCL and SDA are bus pins sampled by clk_i; byte engine drives event pulses
// Notes:   interrupt status cleared by reading it; one Avalon wait state on reads
//
// How it works
// - Data-not-address flag clears when a received address matches own address.
// - Data-not-address flag sets on transmit write or received slave data byte.
// - Stop flag sets on Stop, clears on Start or Repeated Start.
// - Start flag sets on Start or Repeated Start, clears on Stop.
// - Read-not-write flag loads the direction bit after a slave address byte.
// - Receive-full flag sets when a byte lands in receive register; read clears.
// - Transmit-full flag sets on transmit write while not busy, clears when byte sent.
// - Acknowledge flag updates only after transmitting a byte and seeing ACK/NACK.
// - Mask bit one ignores that address bit; zero requires an exact match.
// - Upper six mask bits read zero and ignore writes.
// - Write-collision flag sets on transmit write while busy or transmit-full; software clears it.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "i2c_status_map.vh"
module i2c_status_flags #(
  parameter ADDR_W = 10                     // Own address / mask width
) (
  input  wire        clk_i,                 // System clock, 200 MHz
  input  wire        rstn_i,                // Async reset, active low
  input  wire        ce_i,                  // Clock enable, freezes all state when low
  input  wire [3:0]  avs_address_i,         // Avalon byte address
  input  wire        avs_read_i,            // Avalon read
  input  wire        avs_write_i,           // Avalon write
  input  wire [31:0] avs_writedata_i,       // Avalon write data
  input  wire [3:0]  avs_byteenable_i,      // Avalon byte enables
  output reg  [31:0] avs_readdata_o,        // Avalon read data
  output wire        avs_waitrequest_o,     // Avalon wait request
  input  wire        scl_i,                 // SCL pin level
  input  wire        sda_i,                 // SDA pin level
  input  wire        busy_i,                // Port busy with a transfer
  input  wire        rx_byte_i,             // Pulse: received byte valid
  input  wire [7:0]  rx_data_i,             // Received byte
  input  wire        rx_is_addr_i,          // Received byte is an address byte
  input  wire        rx_is_addr2_i,         // Received byte is 2nd 10-bit address byte
  input  wire        tx_done_i,             // Pulse: byte sent, ack sampled
  input  wire        tx_ack_i,              // Ack level sampled (1 = NACK)
  output reg  [7:0]  tx_data_o,             // Transmit holding register
  output wire        addr_match_o,          // Combinational address match result
  output wire        irq_o                  // Level interrupt
);
  // ---------------------------------------------------------------
  // Pin synchronisers and condition detection
  // ---------------------------------------------------------------
  reg  [1:0] scl_s_q;
  reg  [1:0] sda_s_q;
  reg        scl_d_q;
  reg        sda_d_q;
  wire       start_det = scl_s_q[1] & scl_d_q & sda_d_q & ~sda_s_q[1];
  wire       stop_det  = scl_s_q[1] & scl_d_q & ~sda_d_q & sda_s_q[1];

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else if (ce_i) begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      scl_d_q <= scl_s_q[1];
      sda_d_q <= sda_s_q[1];
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg  [`MASK_W-1:0] mask_q;
  reg  [ADDR_W-1:0]  own_q;
  reg                ten_bit_q;
  reg                tbf_q;
  reg                rbf_q;
  reg                rw_q;
  reg                start_q;
  reg                stop_q;
  reg                da_q;
  reg                wcol_q;
  reg                ack_q;
  reg  [7:0]         rx_q;
  reg  [7:0]         addr_hi_q;
  reg  [`IRQ_W-1:0]  irq_sts_q;
  reg  [`IRQ_W-1:0]  irq_msk_q;
  reg                rd_pend_q;

  wire [1:0] word  = avs_address_i[3:2];
  wire       wr_lo = avs_write_i & avs_byteenable_i[0];
  wire       wr_hi = avs_write_i & avs_byteenable_i[1];
  wire       wr_b2 = avs_write_i & avs_byteenable_i[2];
  wire       tx_wr = wr_lo & (word == `ADR_DATA);
  wire       rd_acc = avs_read_i & rd_pend_q;
  wire       rd_rx = rd_acc & (word == `ADR_DATA);
  wire       rd_st = rd_acc & (word == `ADR_STATUS);

  // ---------------------------------------------------------------
  // Masked address compare
  // ---------------------------------------------------------------
  // 7-bit: address byte bits 7:1 vs own[6:0]; 10-bit: stored high byte bits 2:1 + low byte
  wire [ADDR_W-1:0] in_addr = ten_bit_q ? {addr_hi_q[2:1], rx_data_i}
                                        : {3'h0, rx_data_i[7:1]};
  wire [ADDR_W-1:0] use_msk = ten_bit_q ? {ADDR_W{1'b1}} : {3'h0, 7'h7F};
  wire [ADDR_W-1:0] diff    = (in_addr ^ own_q) & ~mask_q & use_msk;
  wire              hi_hdr  = rx_data_i[7:3] == 5'h1E;
  wire              hi_ok   = hi_hdr & ~(((rx_data_i[2:1] ^ own_q[9:8]) & ~mask_q[9:8]) != 2'h0);
  assign addr_match_o = ten_bit_q ? (rx_is_addr2_i & (diff == {ADDR_W{1'b0}}))
                                  : (rx_is_addr_i & (diff == {ADDR_W{1'b0}}));
  wire   addr_ev = rx_byte_i & (rx_is_addr_i | rx_is_addr2_i);
  wire   data_ev = rx_byte_i & ~rx_is_addr_i & ~rx_is_addr2_i;

  // ---------------------------------------------------------------
  // Flag logic; hardware sets take priority over software clears
  // ---------------------------------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_q    <= `MASK_RST;
      own_q     <= `OWN_RST;
      ten_bit_q <= 1'b0;
      tbf_q     <= 1'b0;
      rbf_q     <= 1'b0;
      rw_q      <= 1'b0;
      start_q   <= 1'b0;
      stop_q    <= 1'b0;
      da_q      <= 1'b0;
      wcol_q    <= 1'b0;
      ack_q     <= 1'b0;
      rx_q      <= 8'h00;
      addr_hi_q <= 8'h00;
      tx_data_o <= 8'h00;
      irq_sts_q <= {`IRQ_W{1'b0}};
      irq_msk_q <= {`IRQ_W{1'b0}};
      rd_pend_q <= 1'b0;
    end else if (ce_i) begin
      rd_pend_q <= avs_read_i & ~rd_pend_q;
      if (wr_lo & (word == `ADR_MASK))
        mask_q[7:0] <= avs_writedata_i[7:0];
      if (wr_hi & (word == `ADR_MASK))
        mask_q[9:8] <= avs_writedata_i[9:8];
      if (wr_lo & (word == `ADR_OWNADDR))
        own_q[7:0] <= avs_writedata_i[7:0];
      if (wr_hi & (word == `ADR_OWNADDR)) begin
        own_q[9:8] <= avs_writedata_i[9:8];
        ten_bit_q  <= avs_writedata_i[`OWN_10B_BIT];
      end
      if (wr_b2 & (word == `ADR_MASK))
        irq_msk_q <= avs_writedata_i[16+`IRQ_W-1:16];
      // Software clears collision flag by writing zero to its bit
      if (wr_lo & (word == `ADR_STATUS) & ~avs_writedata_i[`BIT_WCOL])
        wcol_q <= 1'b0;
      if (tx_wr & (busy_i | tbf_q))
        wcol_q <= 1'b1;
      if (tx_wr & ~busy_i & ~tbf_q)
        tx_data_o <= avs_writedata_i[7:0];
      // Transmit-full
      if (tx_done_i)
        tbf_q <= 1'b0;
      if (tx_wr & ~busy_i)
        tbf_q <= 1'b1;
      if (tx_done_i)
        ack_q <= tx_ack_i;
      // Receive-full; a new byte beats a simultaneous read
      if (rd_rx)
        rbf_q <= 1'b0;
      if (data_ev | (addr_ev & addr_match_o)) begin
        rbf_q <= 1'b1;
        rx_q  <= rx_data_i;
      end
      if (rx_byte_i & rx_is_addr_i & hi_hdr)
        addr_hi_q <= rx_data_i;
      // Direction bit from first address byte
      if (rx_byte_i & rx_is_addr_i & (ten_bit_q ? hi_ok : addr_match_o))
        rw_q <= rx_data_i[0];
      // Data-not-address
      if (addr_ev & addr_match_o)
        da_q <= 1'b0;
      if (tx_wr | data_ev)
        da_q <= 1'b1;
      // Bus conditions, last one seen wins
      if (start_det) begin
        start_q <= 1'b1;
        stop_q  <= 1'b0;
      end else if (stop_det) begin
        start_q <= 1'b0;
        stop_q  <= 1'b1;
      end
      // Interrupt status: read clears, new events win
      irq_sts_q <= (rd_st ? {`IRQ_W{1'b0}} : irq_sts_q)
                   | {tx_wr & (busy_i | tbf_q), tx_done_i, rx_byte_i, start_det, stop_det};
    end
  end

  assign irq_o             = |(irq_sts_q & irq_msk_q);
  assign avs_waitrequest_o = avs_read_i & ~rd_pend_q;

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always @* begin
    avs_readdata_o = 32'h0000_0000;
    case (word)
      `ADR_STATUS: begin
        avs_readdata_o[`BIT_TBF]   = tbf_q;
        avs_readdata_o[`BIT_RBF]   = rbf_q;
        avs_readdata_o[`BIT_RW]    = rw_q;
        avs_readdata_o[`BIT_START] = start_q;
        avs_readdata_o[`BIT_STOP]  = stop_q;
        avs_readdata_o[`BIT_DA]    = da_q;
        avs_readdata_o[`BIT_WCOL]  = wcol_q;
        avs_readdata_o[`BIT_ACK]   = ack_q;
        avs_readdata_o[16+`IRQ_W-1:16] = irq_sts_q;
      end
      `ADR_MASK: begin
        avs_readdata_o[`MASK_W-1:0]    = mask_q;
        avs_readdata_o[16+`IRQ_W-1:16] = irq_msk_q;
      end
      `ADR_OWNADDR: begin
        avs_readdata_o[ADDR_W-1:0]    = own_q;
        avs_readdata_o[`OWN_10B_BIT]  = ten_bit_q;
      end
      `ADR_DATA: avs_readdata_o[7:0] = rx_q;
      default: avs_readdata_o = 32'h0000_0000;
    endcase
  end
endmodule

// ===== hdl/i2c_status_map.vh
// Purpose: register offsets, field positions and reset values of the status/mask block
// Assumes: Avalon-MM, 32-bit data, word addresses in byte units
// Notes:   definitions only
`ifndef I2C_STATUS_MAP_VH
`define I2C_STATUS_MAP_VH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_STATUS   4'h0
`define OFS_MASK     4'h4
`define OFS_OWNADDR  4'h8
`define OFS_TXDATA   4'hC
// Word addresses below, derived from the byte offsets
`define ADR_STATUS   2'h0
`define ADR_MASK     2'h1
`define ADR_OWNADDR  2'h2
`define ADR_DATA     2'h3
// ---------------------------------------------------------------
// Status field positions
// ---------------------------------------------------------------
`define BIT_TBF      0
`define BIT_RBF      1
`define BIT_RW       2
`define BIT_START    3
`define BIT_STOP     4
`define BIT_DA       5
`define BIT_WCOL     7
`define BIT_ACK      15
// Interrupt status / mask positions
`define IRQ_STOP     0
`define IRQ_START    1
`define IRQ_RXBYTE   2
`define IRQ_TXDONE   3
`define IRQ_WCOL     4
`define IRQ_W        5
// ---------------------------------------------------------------
// Reset values and widths
// ---------------------------------------------------------------
`define MASK_RST     10'h000
`define OWN_RST      10'h000
`define MASK_W       10
`define OWN_10B_BIT  15
`endif

// ===== verification/bus_peer.sv
// Purpose: other device on the I2C bus making Start, bit clocks and Stop
// Assumes: 80 ns SCL period inside frames, pull-ups hold idle lines high
// Notes:   SCL stands high between frames; SDA moves while SCL is high only for Start and Stop
`timescale 1ns/1ps
module bus_peer (
  output logic scl_o,  // SCL level
  output logic sda_o   // SDA level
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task start_frame;
    sda_o = 1'b0;
    #40 scl_o = 1'b0;
    repeat (4) begin
      #20 sda_o = ~sda_o;
      #20 scl_o = 1'b1;
      #40 scl_o = 1'b0;
    end
  endtask
  task stop_frame;
    #20 sda_o = 1'b0;
    #20 scl_o = 1'b1;
    #20 sda_o = 1'b1;
  endtask
endmodule

// ===== verification/i2c_status_asserts.sv
// Purpose: assertions on bus timing and status flags of i2c_status_flags
// Assumes: ce_i held high, full byte enables on every write
// Notes:   tbf_q shadows the transmit-full flag from the port events
`timescale 1ns/1ps
module i2c_status_asserts (
  input wire        clk_i,              // System clock
  input wire        rstn_i,             // Reset, active low
  input wire [3:0]  avs_address_i,      // Byte address
  input wire        avs_read_i,         // Read
  input wire        avs_write_i,        // Write
  input wire [31:0] avs_writedata_i,    // Write data
  input wire [31:0] avs_readdata_o,     // Read data
  input wire        avs_waitrequest_o,  // Wait request
  input wire        busy_i,             // Port busy
  input wire        tx_done_i,          // Byte sent
  input wire [7:0]  tx_data_o,          // Transmit holding register
  input wire        irq_o               // Interrupt
);
  reg  tbf_q;
  wire txw = avs_write_i && avs_address_i[3:2] == 2'h3;
  wire rdn = avs_read_i && !avs_waitrequest_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Refused writes never set the shadow
  always @(posedge clk_i or negedge rstn_i)
    if (!rstn_i) tbf_q <= 1'b0;
    else if (txw && !busy_i && !tbf_q) tbf_q <= 1'b1;
    else if (tx_done_i) tbf_q <= 1'b0;
  property p_wr_nowait; avs_write_i |-> !avs_waitrequest_o; endproperty
  property p_rd_first; $rose(avs_read_i) |-> avs_waitrequest_o; endproperty
  property p_rd_second; avs_read_i && avs_waitrequest_o |=> !avs_read_i || !avs_waitrequest_o;
  endproperty
  property p_msk_hi; rdn && avs_address_i[3:2] == 2'h1 |-> avs_readdata_o[15:10] == 6'h00;
  endproperty
  property p_ststop; rdn && avs_address_i[3:2] == 2'h0 |-> !(avs_readdata_o[3] && avs_readdata_o[4]);
  endproperty
  property p_tbf; rdn && avs_address_i[3:2] == 2'h0 |-> avs_readdata_o[0] == tbf_q; endproperty
  property p_txload; txw && !busy_i && !tbf_q |=> tx_data_o == $past(avs_writedata_i[7:0]);
  endproperty
  property p_txkeep; txw && (busy_i || tbf_q) |=> $stable(tx_data_o); endproperty
  property p_irqfall; $fell(irq_o) |-> $past(avs_read_i) || $past(avs_write_i); endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  a_rd_first: assert property (p_rd_first) else $error("read answered at once");
  a_rd_second: assert property (p_rd_second) else $error("read wait too long");
  a_msk_hi: assert property (p_msk_hi) else $error("mask upper bits set");
  a_ststop: assert property (p_ststop) else $error("start and stop both set");
  a_tbf: assert property (p_tbf) else $error("transmit full wrong");
  a_txload: assert property (p_txload) else $error("transmit byte not loaded");
  a_txkeep: assert property (p_txkeep) else $error("refused byte stored");
  a_irqfall: assert property (p_irqfall) else $error("interrupt dropped alone");
  c_txw: cover property (txw);
  c_irq: cover property ($rose(irq_o));
  c_stat: cover property (rdn && avs_address_i[3:2] == 2'h0);
endmodule
bind i2c_status_flags i2c_status_asserts u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .busy_i(busy_i), .tx_done_i(tx_done_i),
  .tx_data_o(tx_data_o), .irq_o(irq_o));

// ===== verification/tb.sv
// Purpose: self-checking bench of i2c_status_flags
// Assumes: one wait state on reads, none on writes
// Notes:   byte engine events are driven by the bench
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module tb;
  logic        clk_i, rstn_i, rd_i, wr_i, busy_i, rx_byte_i, a1_i, a2_i, tx_done_i, m, ack_i;
  logic [3:0]  adr_i;
  logic [7:0]  rxd_i;
  logic [31:0] wd_i, r;
  wire  [31:0] rdata;
  wire  [7:0]  txd;
  wire         wait_o, mt, irq, scl, sda;
  int          fails, samples_checked;
  i2c_status_flags u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .avs_address_i(adr_i),
    .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wd_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .scl_i(scl), .sda_i(sda),
    .busy_i(busy_i), .rx_byte_i(rx_byte_i), .rx_data_i(rxd_i), .rx_is_addr_i(a1_i),
    .rx_is_addr2_i(a2_i), .tx_done_i(tx_done_i), .tx_ack_i(ack_i), .tx_data_o(txd),
    .addr_match_o(mt), .irq_o(irq));
  bus_peer u_peer (.scl_o(scl), .sda_o(sda));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wr_i, rd_i, adr_i, wd_i} <= {w, !w, a, d};
    do @(posedge clk_i); while (wait_o !== 1'b0);
    r = rdata;
    {wr_i, rd_i} <= 2'b00;
  endtask
  task rx(input logic [7:0] d, input logic f1, input logic f2);
    @(posedge clk_i);
    {rxd_i, a1_i, a2_i, rx_byte_i} <= {d, f1, f2, 1'b1};
    #1 m = mt;
    @(posedge clk_i);
    rx_byte_i <= 1'b0;
  endtask
  task give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    {rstn_i, rd_i, wr_i, busy_i, rx_byte_i, a1_i, a2_i, tx_done_i} = 8'h00;
    {adr_i, rxd_i, wd_i, fails, samples_checked} = '0;
    ack_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    xfer(0, 4'h4, 0);
    `CHK(r, 32'h00000000)
    xfer(1, 4'h4, 32'hFFFFFFFF);
    xfer(0, 4'h4, 0);
    `CHK(r, 32'h001F03FF)
    xfer(1, 4'h4, 32'h00000003);
    xfer(1, 4'h8, 32'h00000050);
    rx(8'hAF, 1, 0);
    `CHK(m, 1'b0)
    rx(8'hA7, 1, 0);
    `CHK(m, 1'b1)
    xfer(0, 4'h0, 0);
    `CHK(r[5:0], 6'h06)
    xfer(0, 4'hC, 0);
    rx(8'h5A, 0, 0);
    xfer(0, 4'h0, 0);
    `CHK(r[5:0], 6'h26)
    xfer(0, 4'hC, 0);
    `CHK(r[7:0], 8'h5A)
    xfer(1, 4'hC, 32'h0000003C);
    xfer(1, 4'hC, 32'h00000077);
    xfer(0, 4'h0, 0);
    `CHK({r[7], r[1:0], txd}, {3'b101, 8'h3C})
    @(posedge clk_i);
    tx_done_i <= 1'b1;
    @(posedge clk_i);
    tx_done_i <= 1'b0;
    rx(8'h11, 0, 0);
    xfer(0, 4'h0, 0);
    `CHK({r[15], r[0]}, 2'b10)
    ack_i <= 1'b0;
    @(posedge clk_i);
    tx_done_i <= 1'b1;
    @(posedge clk_i);
    tx_done_i <= 1'b0;
    ack_i <= 1'b1;
    rx(8'h22, 0, 0);
    xfer(0, 4'h0, 0);
    `CHK(r[15], 1'b0)
    xfer(1, 4'h0, 0);
    xfer(0, 4'h0, 0);
    `CHK(r[7], 1'b0)
    busy_i <= 1'b1;
    xfer(1, 4'hC, 32'h00000099);
    busy_i <= 1'b0;
    xfer(0, 4'h0, 0);
    `CHK({r[7], r[0], txd}, {2'b10, 8'h3C})
    xfer(1, 4'h0, 0);
    xfer(0, 4'h0, 0);
    `CHK({r[7], r[0], txd}, {2'b00, 8'h3C})
    u_peer.start_frame;
    repeat (10) @(posedge clk_i);
    `CHK(irq, 1'b0)
    xfer(0, 4'h0, 0);
    `CHK(r[4:3], 2'b01)
    xfer(1, 4'h4, 32'h00010003);
    u_peer.stop_frame;
    repeat (10) @(posedge clk_i);
    `CHK(irq, 1'b1)
    xfer(0, 4'h0, 0);
    `CHK(r[4:3], 2'b10)
    @(posedge clk_i);
    `CHK(irq, 1'b0)
    xfer(1, 4'h4, 0);
    xfer(1, 4'h8, 32'h000082A5);
    rx(8'hF4, 1, 0);
    rx(8'hA5, 0, 1);
    `CHK(m, 1'b1)
    rx(8'hF4, 1, 0);
    rx(8'hA4, 0, 1);
    `CHK(m, 1'b0)
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    give_verdict;
  end
endmodule
